// file: design/rcb_pkg.sv
// package: address, field layout, reset value and carriers for the reference control bank
package rcb_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] RCB_ADDR_REFERENCE_CONTROL = 8'hD1;
    localparam logic [7:0] RCB_RESET_REFERENCE_CONTROL = 8'h00;
    localparam logic [7:0] RCB_IMPL_MASK = 8'h07;

    // ****************************************
    // field positions
    // ****************************************
    localparam int RCB_BIT_REF_BUFFER_ENABLE = 0;
    localparam int RCB_BIT_ANALOG_BIAS_ENABLE = 1;
    localparam int RCB_BIT_TEMP_SENSOR_ENABLE = 2;

    // ****************************************
    // converter mux
    // ****************************************
    localparam int RCB_MUX_CHANNELS = 9;
    localparam logic [3:0] RCB_TEMP_CHANNEL = 4'h8;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcb_sfr_req_t;

    typedef struct packed {
        logic temp_sensor_enable;
        logic analog_bias_enable;
        logic ref_buffer_enable;
    } rcb_enables_t;

    typedef enum logic [1:0] {
        RCB_MODE_OFF = 2'b00,
        RCB_MODE_EXT_REF = 2'b01,
        RCB_MODE_INT_REF = 2'b10,
        RCB_MODE_INVALID = 2'b11
    } rcb_mode_t;

endpackage

// file: design/rcb_enable_reg.sv
// single registered enable level with asynchronous reset
`timescale 1ns/1ns
`default_nettype none

module rcb_enable_reg (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic value,
    // output
    output logic level
);

    // ****************************************
    // storage
    // ****************************************
    logic level_q;
    logic level_d;

    // next value: follow on load, else hold
    assign level_d = load ? value : level_q;

    // flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

    assign level = level_q;

endmodule

`default_nettype wire

// file: design/rcb_reference_control_bank.sv
// reference control bank: special-function register driving analog enables
`timescale 1ns/1ns
`default_nettype none

module rcb_reference_control_bank #(
    parameter int MUX_CHANNELS = rcb_pkg::RCB_MUX_CHANNELS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // special-function register access
    input wire rcb_pkg::rcb_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // converter mux channel in use
    input wire logic [3:0] adc_channel,
    // analog enables
    output rcb_pkg::rcb_enables_t enables,
    output logic ref_buffer_oe_n,
    output logic temp_sensor_oe_n,
    output rcb_pkg::rcb_mode_t ref_mode,
    output logic temp_channel_selected
);

    // ****************************************
    // decode
    // ****************************************
    // one compare function, called once for the read path and once for the write path
    function automatic logic addr_match(input logic [7:0] a);
        addr_match = (a == rcb_pkg::RCB_ADDR_REFERENCE_CONTROL);
    endfunction

    // register write and read strobes
    wire logic wr_hit;
    wire logic rd_hit;
    assign wr_hit = sfr_req.wr && addr_match(sfr_req.addr);
    assign rd_hit = sfr_req.rd && addr_match(sfr_req.addr);

    // ****************************************
    // control bits
    // ****************************************
    // internal levels, one edge ahead of the pins; a write lands in all three at once
    logic buf_en;
    logic bias_en;
    logic temp_en;

    // bit 0: bandgap and buffer
    rcb_enable_reg u_buf (
        .mclk(mclk),
        .rst(rst),
        .load(wr_hit),
        .value(sfr_req.wdata[rcb_pkg::RCB_BIT_REF_BUFFER_ENABLE]),
        .level(buf_en)
    );

    // bit 1: converter bias
    rcb_enable_reg u_bias (
        .mclk(mclk),
        .rst(rst),
        .load(wr_hit),
        .value(sfr_req.wdata[rcb_pkg::RCB_BIT_ANALOG_BIAS_ENABLE]),
        .level(bias_en)
    );

    // bit 2: temperature sensor
    rcb_enable_reg u_temp (
        .mclk(mclk),
        .rst(rst),
        .load(wr_hit),
        .value(sfr_req.wdata[rcb_pkg::RCB_BIT_TEMP_SENSOR_ENABLE]),
        .level(temp_en)
    );

    // ****************************************
    // derived next values
    // ****************************************
    wire logic [7:0] reg_view;
    wire logic [7:0] rdata_d;
    wire rcb_pkg::rcb_mode_t mode_d;
    wire logic [3:0] top_channel;
    wire logic temp_sel_d;
    // upper bits tied off, read as zero
    assign reg_view = {5'h00, temp_en, bias_en, buf_en} & rcb_pkg::RCB_IMPL_MASK;
    assign rdata_d = rd_hit ? reg_view : 8'h00;
    // reference mode as software has set it up: the bandgap needs both bits,
    // an outside reference needs bias alone, buffer without bias is of no use
    assign mode_d = (buf_en && bias_en) ? rcb_pkg::RCB_MODE_INT_REF :
        bias_en ? rcb_pkg::RCB_MODE_EXT_REF :
        buf_en ? rcb_pkg::RCB_MODE_INVALID :
        rcb_pkg::RCB_MODE_OFF;
    // highest mux input carries the sensor
    assign top_channel = 4'(MUX_CHANNELS - 1);
    assign temp_sel_d = (adc_channel == top_channel);

    // ****************************************
    // output flops
    // ****************************************
    // bus response: read data and hit flag stand for one cycle only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else begin
            sfr_rdata <= rdata_d;
            sfr_hit <= rd_hit | wr_hit;
        end
    end

    // analog side: levels retimed so every pin comes from a flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enables <= '0;
            ref_buffer_oe_n <= 1'b1;
            temp_sensor_oe_n <= 1'b1;
            ref_mode <= rcb_pkg::RCB_MODE_OFF;
            temp_channel_selected <= 1'b0;
        end else begin
            enables <= {temp_en, bias_en, buf_en};
            ref_buffer_oe_n <= ~buf_en;
            temp_sensor_oe_n <= ~temp_en;
            ref_mode <= mode_d;
            temp_channel_selected <= temp_sel_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // reset leaves every enable off, both analog outputs floating, the bus quiet
    AST_RESET_ZERO: assert property (@(posedge mclk) $fell(rst) |-> enables == '0)
        else $error("enables not zero after reset");
    AST_RESET_OE: assert property (@(posedge mclk)
        $fell(rst) |-> ref_buffer_oe_n && temp_sensor_oe_n
            && ref_mode == rcb_pkg::RCB_MODE_OFF)
        else $error("outputs not idle after reset");
    AST_RESET_READ: assert property (@(posedge mclk)
        $fell(rst) |-> sfr_rdata == 8'h00 && !sfr_hit)
        else $error("bus response not idle after reset");

    // a write shows on the enables two edges on; without one they hold
    AST_WRITE_FOLLOW: assert property (@(posedge mclk) disable iff (rst)
        wr_hit |-> ##2 enables == $past(sfr_req.wdata[2:0], 2))
        else $error("enables did not follow write");
    AST_BUF_HOLD: assert property (@(posedge mclk) disable iff (rst)
        !wr_hit |-> ##2 $stable(enables.ref_buffer_enable))
        else $error("buffer enable changed without write");
    AST_BIAS_HOLD: assert property (@(posedge mclk) disable iff (rst)
        !wr_hit |-> ##2 $stable(enables.analog_bias_enable))
        else $error("bias changed without write");
    AST_TEMP_HOLD: assert property (@(posedge mclk) disable iff (rst)
        !wr_hit |-> ##2 $stable(enables.temp_sensor_enable))
        else $error("sensor enable changed without write");

    // analog outputs float exactly while their enable is clear
    AST_BUF_TRISTATE: assert property (@(posedge mclk) disable iff (rst)
        ref_buffer_oe_n == !enables.ref_buffer_enable)
        else $error("buffer enable and tristate disagree");
    AST_TEMP_TRISTATE: assert property (@(posedge mclk) disable iff (rst)
        temp_sensor_oe_n == !enables.temp_sensor_enable)
        else $error("sensor enable and tristate disagree");

    // bus answers: hit for one cycle, data only after a read of this address
    AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (rst)
        sfr_rdata[7:3] == 5'h00)
        else $error("unimplemented bits read nonzero");
    AST_READBACK: assert property (@(posedge mclk) disable iff (rst)
        rd_hit |=> sfr_rdata[2:0] == enables)
        else $error("readback mismatch");
    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (rst)
        !rd_hit |=> sfr_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_HIT: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit || wr_hit) |=> sfr_hit)
        else $error("access not acknowledged");
    AST_NO_HIT: assert property (@(posedge mclk) disable iff (rst)
        !(rd_hit || wr_hit) |=> !sfr_hit)
        else $error("hit without access");
    AST_REFUSED: assert property (@(posedge mclk) disable iff (rst)
        (sfr_req.wr || sfr_req.rd) && sfr_req.addr != rcb_pkg::RCB_ADDR_REFERENCE_CONTROL
            |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("foreign address answered");

    // sensor channel flag follows the mux selection one edge later
    AST_TEMP_CHANNEL: assert property (@(posedge mclk) disable iff (rst)
        adc_channel == top_channel |=> temp_channel_selected)
        else $error("top channel not flagged as sensor");
    AST_OTHER_CHANNEL: assert property (@(posedge mclk) disable iff (rst)
        adc_channel != top_channel |=> !temp_channel_selected)
        else $error("other channel flagged as sensor");

    // reported mode matches the bit pair that it stands for
    AST_MODE: assert property (@(posedge mclk) disable iff (rst)
        ref_mode == rcb_pkg::RCB_MODE_INT_REF |-> enables[1:0] == 2'b11)
        else $error("mode mismatch");
    AST_MODE_EXT: assert property (@(posedge mclk) disable iff (rst)
        ref_mode == rcb_pkg::RCB_MODE_EXT_REF |-> enables[1:0] == 2'b10)
        else $error("external mode mismatch");
    AST_MODE_OFF: assert property (@(posedge mclk) disable iff (rst)
        ref_mode == rcb_pkg::RCB_MODE_OFF |-> enables[1:0] == 2'b00)
        else $error("off mode mismatch");
    AST_MODE_INVALID: assert property (@(posedge mclk) disable iff (rst)
        ref_mode == rcb_pkg::RCB_MODE_INVALID |-> enables[1:0] == 2'b01)
        else $error("invalid mode mismatch");

    // main scenarios
    COV_INT_REF: cover property (@(posedge mclk) ref_mode == rcb_pkg::RCB_MODE_INT_REF);
    COV_EXT_REF: cover property (@(posedge mclk) ref_mode == rcb_pkg::RCB_MODE_EXT_REF);
    COV_TEMP_ON: cover property (@(posedge mclk) enables.temp_sensor_enable);
    COV_READ: cover property (@(posedge mclk) rd_hit);
    COV_WRITE: cover property (@(posedge mclk) wr_hit);

endmodule

`default_nettype wire

// file: tb/reference_control_bank_tb_top.sv
// testbench for the reference control bank
`timescale 1ns/1ns
`default_nettype none

module reference_control_bank_tb_top;

    // ****************************************
    // signals
    // ****************************************
    logic mclk;
    logic rst;
    rcb_pkg::rcb_sfr_req_t req;
    logic [3:0] adc_channel;
    logic [7:0] rdata;
    logic hit;
    rcb_pkg::rcb_enables_t enables;
    logic buf_oe_n;
    logic temp_oe_n;
    rcb_pkg::rcb_mode_t ref_mode;
    logic temp_sel;
    int fail_count;
    int n_checks;
    logic [7:0] d;

    rcb_reference_control_bank i_dut (
        .mclk(mclk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata), .sfr_hit(hit),
        .adc_channel(adc_channel), .enables(enables), .ref_buffer_oe_n(buf_oe_n),
        .temp_sensor_oe_n(temp_oe_n), .ref_mode(ref_mode), .temp_channel_selected(temp_sel)
    );

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ****************************************
    // tasks
    // ****************************************
    // compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle write strobe; returns when the enables have settled
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge mclk);
        req = '0;
        chk("write hit", {7'h00, hit}, {7'h00, addr == rcb_pkg::RCB_ADDR_REFERENCE_CONTROL});
        @(negedge mclk);
    endtask

    // one-cycle read strobe, data looked at in its single valid cycle
    task automatic rd_reg(input logic [7:0] addr, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge mclk);
        req = '0;
        chk("read data", rdata, exp);
        chk("read hit", {7'h00, hit}, {7'h00, addr == rcb_pkg::RCB_ADDR_REFERENCE_CONTROL});
        @(negedge mclk);
    endtask

    // mode that a bit set stands for: bit 1 bias, bit 0 buffer
    function automatic logic [1:0] exp_mode(input logic [2:0] e);
        case (e[1:0])
            2'b11: exp_mode = rcb_pkg::RCB_MODE_INT_REF;
            2'b10: exp_mode = rcb_pkg::RCB_MODE_EXT_REF;
            2'b00: exp_mode = rcb_pkg::RCB_MODE_OFF;
            default: exp_mode = rcb_pkg::RCB_MODE_INVALID;
        endcase
    endfunction

    // all enable-derived outputs against one expected bit set
    task automatic chk_outs(input logic [2:0] e);
        chk("enables", {5'h00, enables}, {5'h00, e});
        chk("buffer oe_n", {7'h00, buf_oe_n}, {7'h00, ~e[0]});
        chk("sensor oe_n", {7'h00, temp_oe_n}, {7'h00, ~e[2]});
        chk("mode", {6'h00, ref_mode}, {6'h00, exp_mode(e)});
    endtask

    // verdict and end of run
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fail_count = 0;
        n_checks = 0;
        rst = 1'b1;
        req = '0;
        adc_channel = 4'h0;
        d = 8'h00;
        repeat (16) @(negedge mclk);
        chk_outs(3'h0);
        chk("reset rdata", rdata, 8'h00);
        rst = 1'b0;
        @(negedge mclk);
        rd_reg(rcb_pkg::RCB_ADDR_REFERENCE_CONTROL, rcb_pkg::RCB_RESET_REFERENCE_CONTROL);
        // every enable combination, with the unused upper bits set
        for (int i = 0; i < 8; i++) begin
            d = 8'hF8 | i[7:0];
            wr_reg(rcb_pkg::RCB_ADDR_REFERENCE_CONTROL, d);
            chk_outs(d[2:0]);
            rd_reg(rcb_pkg::RCB_ADDR_REFERENCE_CONTROL, d & rcb_pkg::RCB_IMPL_MASK);
        end
        // neighbouring addresses are ignored
        wr_reg(8'hD0, 8'h00);
        chk_outs(3'h7);
        rd_reg(8'hD2, 8'h00);
        // sensor channel detection on the top mux input
        adc_channel = rcb_pkg::RCB_TEMP_CHANNEL;
        @(negedge mclk);
        chk("temp channel", {7'h00, temp_sel}, 8'h01);
        adc_channel = 4'h7;
        @(negedge mclk);
        chk("other channel", {7'h00, temp_sel}, 8'h00);
        // reset in mid-run clears every enable
        rst = 1'b1;
        @(negedge mclk);
        chk_outs(3'h0);
        rst = 1'b0;
        @(negedge mclk);
        rd_reg(rcb_pkg::RCB_ADDR_REFERENCE_CONTROL, 8'h00);
        finish_test();
    end

endmodule

`default_nettype wire
